// ===== hw/psp_pkg.sv
// Purpose: constants and types shared by the serial port and output pin logic
// Assumes: 24-bit register words, 6-bit register address space
// Notes: byte offsets are register numbers on the serial link, not bus addresses
package psp_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [5:0] PSP_OFF_ID_CMD = 6'h00;
    localparam logic [5:0] PSP_OFF_OUT_CTRL = 6'h0f;
    localparam int PSP_WORD_W = 24;
    localparam int PSP_ADDR_W = 6;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PSP_CMD_RDADDR_MSB = 4;
    localparam int PSP_CMD_SOFTRST_BIT = 5;
    localparam int PSP_CMD_STROBE_LSB = 6;
    localparam int PSP_OC_SEL_MSB = 4;
    localparam int PSP_OC_NOMUX_BIT = 6;
    localparam int PSP_OC_FORCE_ON_BIT = 7;
    localparam int PSP_OC_NO_PULLUP_BIT = 8;
    localparam int PSP_OC_NO_PULLDN_BIT = 9;
    localparam logic [23:0] PSP_OUT_CTRL_RESET = 24'h000001;

    // ************************************************************
    // frame positions, counted in serial clock rising edges
    // ************************************************************
    localparam logic [5:0] PSP_EDGE_DIR = 6'h01;
    localparam logic [5:0] PSP_EDGE_ADDR_LAST = 6'h07;
    localparam logic [5:0] PSP_EDGE_DATA_FIRST = 6'h08;
    localparam logic [5:0] PSP_EDGE_DATA_LAST = 6'h1f;
    localparam logic [5:0] PSP_EDGE_FRAME_END = 6'h20;
    localparam logic [5:0] PSP_EDGE_MAX = 6'h3f;
    localparam logic [2:0] PSP_CHIP_ADDR = 3'h0;

    typedef enum logic [1:0] {PSP_MODE_UNDECIDED, PSP_MODE_LEGACY, PSP_MODE_MULTIDROP} psp_mode_t;

endpackage

// ===== hw/psp_serial_port.sv
// Purpose: serial slave port with mode detection and shared output pin control
// Assumes: serial pins are asynchronous and slow against clk; rst_b is power-on reset
// Notes: registers other than 00h and 0fh live outside and are reached by the write and read ports
`timescale 1ns/1ps

// Overview of operation
// - register zero reads a fixed version word
// - pin tri-stated after reset, drives addressed reads
// - legacy: drive only last 24 read bits
// - multidrop: drive when chip address is zero
// - output control bit 7 forces driver on
// - auto switch to read data, bit 6 blocks
// - keep-off input low: drive while disabled
// - master enable low disables driver entirely
// - bits 8 and 9 disable pull halves
// - early enable rise with zero address writes nothing
// - multidrop read spans first clock to enable
// - five-bit select picks general output, default lock
// - register zero write: address, soft reset, strobes
// - first edge after reset fixes the mode
// - five-bit addresses, legacy accepts six bits
// - legacy frame: direction, six address, 24 data
// - legacy first rising edge gives direction
// - legacy address on edges two to seven
// - legacy write data 8-31, commit at 32
// - legacy read data out on edges 8-31
// - legacy read returns pin at edge 32
// - multidrop frame commits on enable rise
module psp_serial_port
    import psp_pkg::*;
#(
    parameter logic [23:0] VERSION_WORD = 24'h000a5c, // arbitrary value
    parameter int NUM_SOURCES = 32
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_clk,
    input wire logic serial_enable,
    input wire logic serial_data_in,
    input wire logic lock_indicator,
    input wire logic [NUM_SOURCES-1:0] general_output_signal,
    input wire logic chip_enabled,
    input wire logic keep_off_when_disabled,
    input wire logic driver_master_enable,
    input wire logic [23:0] ext_rd_data,
    output logic [5:0] ext_rd_addr,
    output logic lock_or_readback_pin_o,
    output logic lock_or_readback_pin_oe,
    output logic pullup_enable,
    output logic pulldown_enable,
    output logic wr_stb,
    output logic [5:0] wr_addr,
    output logic [23:0] wr_data,
    output logic soft_reset_pulse,
    output logic strobe_pulse,
    output logic [17:0] general_strobes,
    output psp_mode_t link_mode
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic ena_s1;
        logic ena_s2;
        logic ena_s3;
        logic sdi_s1;
        logic sdi_s2;
        psp_mode_t mode;
        logic [5:0] edge_cnt;
        logic [31:0] shift;
        logic [23:0] rd_shift;
        logic sdo_bit;
        logic read_act;
        logic leg_read;
        logic [4:0] rd_addr;
        logic [23:0] out_ctrl;
        logic wr_stb;
        logic [5:0] wr_addr;
        logic [23:0] wr_data;
        logic soft_rst;
        logic strobe;
        logic [17:0] strobes;
    } psp_state_t;

    localparam psp_state_t PSP_STATE_RESET = '{
        mode: PSP_MODE_UNDECIDED,
        out_ctrl: PSP_OUT_CTRL_RESET,
        default: '0
    };

    psp_state_t st_q;
    psp_state_t st_d;
    logic [5:0] rd_addr_sel;
    logic [23:0] rd_word;

    // ************************************************************
    // read decode
    // ************************************************************
    function automatic logic [23:0] read_word(input logic [5:0] addr, input logic [23:0] out_ctrl,
                                              input logic [23:0] ext);
        logic [23:0] w;
        w = ext;
        if (addr == PSP_OFF_ID_CMD)
        begin
            w = VERSION_WORD;
        end
        else if (addr == PSP_OFF_OUT_CTRL)
        begin
            w = out_ctrl;
        end
        return w;
    endfunction

    always_comb
    begin
        // legacy reads address by the six bits just shifted, multidrop by the stored read address
        if (st_q.mode == PSP_MODE_LEGACY)
        begin
            rd_addr_sel = {st_q.shift[4:0], st_q.sdi_s2};
        end
        else
        begin
            rd_addr_sel = {1'b0, st_q.rd_addr};
        end
        rd_word = read_word(rd_addr_sel, st_q.out_ctrl, ext_rd_data);
    end

    assign ext_rd_addr = rd_addr_sel;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic sclk_rise;
        logic ena_rise;
        logic ena_fall;
        logic [5:0] n;
        logic commit;
        logic [5:0] c_addr;
        logic [23:0] c_data;
        sclk_rise = 1'b0;
        ena_rise = 1'b0;
        ena_fall = 1'b0;
        n = '0;
        commit = 1'b0;
        c_addr = '0;
        c_data = '0;
        st_d = st_q;
        st_d.sclk_s1 = serial_clk;
        st_d.sclk_s2 = st_q.sclk_s1;
        st_d.sclk_s3 = st_q.sclk_s2;
        st_d.ena_s1 = serial_enable;
        st_d.ena_s2 = st_q.ena_s1;
        st_d.ena_s3 = st_q.ena_s2;
        st_d.sdi_s1 = serial_data_in;
        st_d.sdi_s2 = st_q.sdi_s1;
        st_d.wr_stb = 1'b0;
        st_d.soft_rst = 1'b0;
        st_d.strobe = 1'b0;
        sclk_rise = st_q.sclk_s2 && !st_q.sclk_s3;
        ena_rise = st_q.ena_s2 && !st_q.ena_s3;
        ena_fall = !st_q.ena_s2 && st_q.ena_s3;
        if (st_q.edge_cnt != PSP_EDGE_MAX)
        begin
            n = 6'(st_q.edge_cnt + 6'h01);
        end
        else
        begin
            n = PSP_EDGE_MAX;
        end

        // enable wins a tie, since it is the legacy frame start
        if (st_q.mode == PSP_MODE_UNDECIDED)
        begin
            if (ena_rise)
            begin
                st_d.mode = PSP_MODE_LEGACY;
            end
            else if (sclk_rise)
            begin
                st_d.mode = PSP_MODE_MULTIDROP;
            end
        end

        if (st_d.mode == PSP_MODE_LEGACY)
        begin
            if (ena_rise || ena_fall)
            begin
                st_d.edge_cnt = '0;
                st_d.shift = '0;
                st_d.read_act = 1'b0;
            end
            else if (sclk_rise && st_q.ena_s2)
            begin
                st_d.edge_cnt = n;
                if (n == PSP_EDGE_DIR)
                begin
                    st_d.leg_read = st_q.sdi_s2;
                end
                else if (n <= PSP_EDGE_DATA_LAST)
                begin
                    st_d.shift = {st_q.shift[30:0], st_q.sdi_s2};
                end
                if (n == PSP_EDGE_ADDR_LAST)
                begin
                    st_d.rd_shift = rd_word;
                end
                if (st_q.leg_read && n >= PSP_EDGE_DATA_FIRST && n <= PSP_EDGE_DATA_LAST)
                begin
                    st_d.sdo_bit = st_q.rd_shift[23];
                    st_d.rd_shift = {st_q.rd_shift[22:0], 1'b0};
                    st_d.read_act = 1'b1;
                end
                if (n == PSP_EDGE_FRAME_END)
                begin
                    st_d.read_act = 1'b0;
                    commit = !st_q.leg_read;
                    c_addr = st_q.shift[29:24];
                    c_data = st_q.shift[23:0];
                end
            end
        end
        else if (st_d.mode == PSP_MODE_MULTIDROP)
        begin
            if (ena_rise)
            begin
                commit = st_q.edge_cnt >= PSP_EDGE_FRAME_END && st_q.shift[2:0] == PSP_CHIP_ADDR;
                c_addr = {1'b0, st_q.shift[7:3]};
                c_data = st_q.shift[31:8];
                st_d.read_act = 1'b0;
                st_d.edge_cnt = '0;
                st_d.shift = '0;
            end
            else if (sclk_rise && !st_q.ena_s2)
            begin
                st_d.edge_cnt = n;
                st_d.shift = {st_q.shift[30:0], st_q.sdi_s2};
                st_d.read_act = 1'b1;
                if (st_q.edge_cnt == '0)
                begin
                    st_d.sdo_bit = rd_word[23];
                    st_d.rd_shift = {rd_word[22:0], 1'b0};
                end
                else
                begin
                    st_d.sdo_bit = st_q.rd_shift[23];
                    st_d.rd_shift = {st_q.rd_shift[22:0], 1'b0};
                end
            end
        end

        if (commit)
        begin
            st_d.wr_stb = 1'b1;
            st_d.wr_addr = c_addr;
            st_d.wr_data = c_data;
            if (c_addr == PSP_OFF_ID_CMD)
            begin
                st_d.rd_addr = c_data[PSP_CMD_RDADDR_MSB:0];
                st_d.strobe = 1'b1;
                st_d.strobes = c_data[23:PSP_CMD_STROBE_LSB];
                if (c_data[PSP_CMD_SOFTRST_BIT])
                begin
                    // soft reset leaves the chosen mode alone
                    st_d.soft_rst = 1'b1;
                    st_d.rd_addr = '0;
                    st_d.out_ctrl = PSP_OUT_CTRL_RESET;
                end
            end
            else if (c_addr == PSP_OFF_OUT_CTRL)
            begin
                st_d.out_ctrl = c_data;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q <= PSP_STATE_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // output pin
    // ************************************************************
    logic [NUM_SOURCES-1:0] sources;
    logic gen_out_bit;
    logic read_drive;
    logic drive;

    always_comb
    begin
        sources = general_output_signal;
        sources[1] = lock_indicator;
        gen_out_bit = sources[st_q.out_ctrl[PSP_OC_SEL_MSB:0]];
        if (st_q.mode == PSP_MODE_MULTIDROP)
        begin
            read_drive = st_q.read_act && st_q.shift[2:0] == PSP_CHIP_ADDR;
        end
        else
        begin
            read_drive = st_q.read_act && st_q.mode == PSP_MODE_LEGACY;
        end
        // host should only trust the lock level between frames: enable low in legacy, enable high in multidrop
        drive = driver_master_enable
            && (chip_enabled || !keep_off_when_disabled)
            && (st_q.out_ctrl[PSP_OC_FORCE_ON_BIT] || read_drive);
    end

    assign lock_or_readback_pin_o = (read_drive && !st_q.out_ctrl[PSP_OC_NOMUX_BIT]) ? st_q.sdo_bit : gen_out_bit;
    assign lock_or_readback_pin_oe = drive;
    assign pullup_enable = drive && !st_q.out_ctrl[PSP_OC_NO_PULLUP_BIT];
    assign pulldown_enable = drive && !st_q.out_ctrl[PSP_OC_NO_PULLDN_BIT];
    assign wr_stb = st_q.wr_stb;
    assign wr_addr = st_q.wr_addr;
    assign wr_data = st_q.wr_data;
    assign soft_reset_pulse = st_q.soft_rst;
    assign strobe_pulse = st_q.strobe;
    assign general_strobes = st_q.strobes;
    assign link_mode = st_q.mode;

endmodule

// ===== verif/psp_serial_port_monitor.sv
// Purpose: port-level checker for the serial port block
// Assumes: one clk domain, synchronous active-low reset
// Notes: commit pulses are expected in the same cycle as wr_stb
`timescale 1ns/1ps
module psp_serial_port_monitor
    import psp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_enable,
    input wire logic chip_enabled,
    input wire logic keep_off_when_disabled,
    input wire logic driver_master_enable,
    input wire logic lock_or_readback_pin_oe,
    input wire logic pullup_enable,
    input wire logic pulldown_enable,
    input wire logic wr_stb,
    input wire logic [5:0] wr_addr,
    input wire logic [23:0] wr_data,
    input wire logic soft_reset_pulse,
    input wire logic strobe_pulse,
    input wire logic [17:0] general_strobes,
    input psp_mode_t link_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_reset_idle: assert property ($rose(rst_b) |-> !lock_or_readback_pin_oe && link_mode == PSP_MODE_UNDECIDED)
        else $error("driver or mode not idle after reset");
    a_master_off: assert property (!driver_master_enable |-> !lock_or_readback_pin_oe)
        else $error("driver on while master enable low");
    a_keep_off: assert property (!chip_enabled && keep_off_when_disabled |-> !lock_or_readback_pin_oe)
        else $error("driver on while chip disabled");
    a_pull_gated: assert property (pullup_enable || pulldown_enable |-> lock_or_readback_pin_oe)
        else $error("pull half on without driver enable");
    a_mode_fixed: assert property (link_mode != PSP_MODE_UNDECIDED |=> $stable(link_mode))
        else $error("link mode changed after decision");
    a_wr_pulse: assert property (wr_stb |=> !wr_stb)
        else $error("write strobe longer than one cycle");
    a_soft_pair: assert property (soft_reset_pulse |-> wr_stb && strobe_pulse && wr_addr == PSP_OFF_ID_CMD && wr_data[5])
        else $error("soft reset without register zero write");
    a_strobe_field: assert property (strobe_pulse |-> general_strobes == wr_data[23:6])
        else $error("general strobes differ from written bits");
    a_legacy_idle: assert property ((link_mode == PSP_MODE_LEGACY && !serial_enable) [*8] |-> !lock_or_readback_pin_oe)
        else $error("legacy driver on outside a frame");
endmodule

bind psp_serial_port psp_serial_port_monitor u_psp_serial_port_monitor (.clk(clk), .rst_b(rst_b),
    .serial_enable(serial_enable), .chip_enabled(chip_enabled), .keep_off_when_disabled(keep_off_when_disabled),
    .driver_master_enable(driver_master_enable), .lock_or_readback_pin_oe(lock_or_readback_pin_oe),
    .pullup_enable(pullup_enable), .pulldown_enable(pulldown_enable), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .soft_reset_pulse(soft_reset_pulse), .strobe_pulse(strobe_pulse),
    .general_strobes(general_strobes), .link_mode(link_mode));

// ===== verif/psp_host.sv
// Purpose: host serial master driving both frame kinds
// Assumes: 125 ns link clock, unrelated to clk
// Notes: link clock stands still between frames
`timescale 1ns/1ps
module psp_host
(
    output logic serial_clk,
    output logic serial_enable,
    output logic serial_data_in,
    input wire logic pin_level,
    input wire logic pin_oe
);
    logic saw_oe;

    initial
    begin
        serial_clk = 1'b0;
        serial_enable = 1'b0;
        serial_data_in = 1'b0;
        saw_oe = 1'b0;
    end

    // data moves on falling edges, read bits taken on falling edges
    task automatic shift(input logic [31:0] v, input int lo, input int hi, output logic [23:0] rd);
        serial_data_in = v[31];
        #62.5;
        for (int i = 1; i <= 32; i++)
        begin
            serial_clk = 1'b1;
            #62.5;
            serial_clk = 1'b0;
            saw_oe |= pin_oe;
            if (i >= lo && i <= hi)
                rd = {rd[22:0], pin_level};
            if (i < 32)
                serial_data_in = v[31-i];
            #62.5;
        end
        serial_data_in = ~serial_data_in;
    endtask

    task automatic legacy(input logic dir, input logic [5:0] a, input logic [23:0] d, output logic [23:0] rd);
        // step off the clk edge the caller returned on
        #1;
        saw_oe = 1'b0;
        serial_data_in = dir;
        serial_enable = 1'b1;
        shift({dir, a, d, 1'b0}, 8, 31, rd);
        serial_enable = 1'b0;
        #300;
    endtask

    task automatic md(input logic [31:0] w, output logic [23:0] rd);
        #1;
        saw_oe = 1'b0;
        serial_enable = 1'b0;
        shift(w, 1, 24, rd);
        serial_enable = 1'b1;
        #300;
    endtask
endmodule

// ===== verif/psp_serial_port_tb.sv
// Purpose: self-checking bench for the serial port block
// Assumes: seed 64, both link modes via a second reset
// Notes: external registers answer with a pattern of their address
`timescale 1ns/1ps
module psp_serial_port_tb;
    import psp_pkg::*;
    localparam logic [23:0] VER = 24'h3c5a17; // arbitrary value
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic lock_indicator = 1'b0;
    logic [31:0] gos = '0;
    logic chip_enabled = 1'b1;
    logic keep_off = 1'b0;
    logic drv_en = 1'b1;
    logic pin_last = 1'b0;
    wire logic sck, ser_en, sdi, pin_w;
    logic [5:0] ext_rd_addr, wr_addr;
    logic [23:0] wr_data, rd;
    logic [17:0] general_strobes;
    logic pin_o, pin_oe, pu, pd, wr_stb, srp, stp;
    psp_mode_t link_mode;
    int bad_count = 0;
    int n_tests = 0;
    int stb_cnt = 0;
    int soft_cnt = 0;

    function automatic logic [23:0] ext_word(input logic [5:0] a);
        return {a, ~a, a, ~a};
    endfunction

    always #5 clk = ~clk;
    // released line shows the inverse of its last driven level
    assign pin_w = pin_oe ? pin_o : ~pin_last;

    always @(posedge clk)
    begin
        if (pin_oe)
            pin_last <= pin_o;
        if (wr_stb)
            stb_cnt++;
        if (srp)
            soft_cnt++;
        lock_indicator <= 1'($urandom);
        gos <= $urandom;
    end

    psp_serial_port #(.VERSION_WORD(VER)) u_psp_serial_port (.clk(clk), .rst_b(rst_b), .serial_clk(sck),
        .serial_enable(ser_en), .serial_data_in(sdi), .lock_indicator(lock_indicator), .general_output_signal(gos),
        .chip_enabled(chip_enabled), .keep_off_when_disabled(keep_off), .driver_master_enable(drv_en),
        .ext_rd_data(ext_word(ext_rd_addr)), .ext_rd_addr(ext_rd_addr), .lock_or_readback_pin_o(pin_o),
        .lock_or_readback_pin_oe(pin_oe), .pullup_enable(pu), .pulldown_enable(pd), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .soft_reset_pulse(srp), .strobe_pulse(stp),
        .general_strobes(general_strobes), .link_mode(link_mode));

    psp_host u_psp_host (.serial_clk(sck), .serial_enable(ser_en), .serial_data_in(sdi), .pin_level(pin_w),
        .pin_oe(pin_oe));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        close_out();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        logic [5:0] a;
        logic [23:0] d;
        int n;
        void'($urandom(64));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 6'h01 : 6'($urandom_range(16, 63));
            d = 24'($urandom);
            n = stb_cnt;
            u_psp_host.legacy(1'b0, a, d, rd);
            check(stb_cnt - n, 1);
            check(wr_addr, a);
            check(wr_data, d);
            check(u_psp_host.saw_oe, 0);
        end
        check(link_mode, PSP_MODE_LEGACY);
        u_psp_host.legacy(1'b1, PSP_OFF_ID_CMD, 24'h0, rd);
        check(rd, VER);
        check(pin_oe, 0);
        u_psp_host.legacy(1'b1, PSP_OFF_OUT_CTRL, 24'h0, rd);
        check(rd, PSP_OUT_CTRL_RESET);
        a = 6'($urandom_range(1, 14));
        u_psp_host.legacy(1'b1, a, 24'h0, rd);
        check(rd, ext_word(a));
        @(negedge clk);
        check(pin_o, lock_indicator);
        n = soft_cnt;
        d = {18'($urandom), 6'h20};
        u_psp_host.legacy(1'b0, PSP_OFF_ID_CMD, d, rd);
        check(soft_cnt - n, 1);
        check(general_strobes, d[23:6]);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        // readback frames carry zero data: any one bit in the live chip address window drops the driver
        u_psp_host.md({24'h000000, 5'h01, 3'h0}, rd);
        check(rd, VER);
        u_psp_host.md({24'h0001c1, 5'h0f, 3'h0}, rd);
        check(link_mode, PSP_MODE_MULTIDROP);
        @(negedge clk);
        check({pin_oe, pu, pd}, 3'b101);
        check(pin_o, lock_indicator);
        u_psp_host.md({24'h000001, 5'h0f, 3'h0}, rd);
        u_psp_host.md({24'h00000f, 5'h00, 3'h0}, rd);
        check(pin_oe, 0);
        u_psp_host.md({24'h000000, 5'h01, 3'h0}, rd);
        check(rd, 24'h000001);
        for (int i = 0; i < 3; i++)
        begin
            a = 6'($urandom_range(1, 14));
            d = 24'($urandom);
            n = stb_cnt;
            u_psp_host.md({d, a[4:0], (i == 2) ? 3'h5 : 3'h0}, rd);
            check(stb_cnt - n, (i == 2) ? 0 : 1);
            if (i < 2)
                check({wr_addr, wr_data}, {a, d});
        end
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            chip_enabled <= (i == 2);
            keep_off <= (i == 1);
            drv_en <= (i != 2);
            u_psp_host.md({24'h00000f, 5'h00, 3'h0}, rd);
            check(u_psp_host.saw_oe, i == 0);
        end
        close_out();
    end
endmodule
